// file: hw/i2cs_defines.svh
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH

// own 7-bit address and the two address bytes it yields
`define I2CS_DEV_ADDR      7'h1E
`define I2CS_WR_ADDR_BYTE  {`I2CS_DEV_ADDR, 1'b0}
`define I2CS_RD_ADDR_BYTE  {`I2CS_DEV_ADDR, 1'b1}
// upper five bits of the high-speed master code
`define I2CS_HS_CODE       5'h01
// data bits per byte
`define I2CS_BIT_CNT       4'h8
// write queue shape
`define I2CS_FIFO_DEPTH    4
`define I2CS_FIFO_WIDTH    16

`endif

// file: hw/i2cs_pkg.sv
`default_nettype none
package i2cs_pkg;

	// serial engine states, one-hot
	typedef enum logic [4:0] {
		ST_WAIT = 5'h01,
		ST_RX   = 5'h02,
		ST_ACKS = 5'h04,
		ST_TX   = 5'h08,
		ST_MACK = 5'h10
	} i2cs_fsm_type;

	// meaning of the byte being received
	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_PTR  = 2'h1,
		PH_DATA = 2'h2
	} i2cs_phase_type;

	// one register write handed to the register bank
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} i2cs_wr_type;

endpackage
`default_nettype wire

// file: hw/i2cs_port.sv
// Contract
// - answer only address 0x1E, bytes 0x3C/0x3D
// - work at any bus rate up to 3.4MHz
// - slow filter set at power-up and stop
// - master code switches to high-speed filters
// - write: acknowledge address and pointer
// - single write data may be nacked
// - commit data on next SDA rise after ack
// - stop restores slow filters, repeat start keeps
// - sequential write acks, stores consecutive registers; code nacks bytes while queue full or a byte pending
// - last ack level of write is don't-care
// - read: ack both address phases and pointer
// - send eight bits MSB first from pointer
// - stop leaves register pointer untouched
// - master ack requests the next register
// - master code 00001xxx gets a nack
// - acknowledge every pointer value
// - never hold SCL low, keep pace
// - ignore SCL until next start
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defines.svh"

// write queue: head always sits in word 0, so outputs are flops
module i2cs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output var  logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	// whole queue state
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0]               cnt;
		logic                        valid;
		logic                        full;
	} i2cs_fifo_state_type;

	i2cs_fifo_state_type st_q;  // registered state
	i2cs_fifo_state_type st_d;  // next state
	logic                push;  // word taken in
	logic                pop;   // word handed out
	logic [CW-1:0]       wi;    // slot for incoming word

	// shift on pop, write behind the last live word
	always_comb begin
		st_d = st_q;
		push = in_valid & ~st_q.full;
		pop  = out_ready & st_q.valid;
		wi   = st_q.cnt - CW'(pop);
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				st_d.mem[i] = st_q.mem[i+1];
			end
		end
		if (push) begin
			st_d.mem[wi] = in_data;
		end
		st_d.cnt   = st_q.cnt + CW'(push) - CW'(pop);
		st_d.valid = (st_d.cnt != '0);
		st_d.full  = (st_d.cnt == CW'(DEPTH));
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign in_ready  = ~st_q.full;
	assign out_valid = st_q.valid;
	assign out_data  = st_q.mem[0];
endmodule

// two-wire register slave port, sampled on core_clk
module i2cs_port
	import i2cs_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe,
	output var  logic        hs_filter_sel,
	output var  logic [7:0]  reg_ptr,
	input  wire logic [7:0]  rd_data,
	output var  logic        wr_valid,
	output var  i2cs_wr_type wr_entry,
	input  wire logic        wr_ready
);
	// whole engine state
	typedef struct packed {
		logic           scl_m;    // scl first sync stage
		logic           scl_s;    // scl second sync stage
		logic           scl_p;    // scl one sample ago
		logic           sda_m;    // sda first sync stage
		logic           sda_s;    // sda second sync stage
		logic           sda_p;    // sda one sample ago
		i2cs_fsm_type   state;    // engine state
		i2cs_fsm_type   after;    // state after ack slot
		i2cs_phase_type phase;    // kind of byte received
		logic [3:0]     cnt;      // bit counter
		logic [7:0]     sh;       // shift register
		logic [7:0]     ptr;      // register pointer
		logic           more;     // master asked for more
		logic           oe;       // pulling sda low
		logic           sda_o;    // level driven, always low
		logic           hs;       // high-speed filters chosen
		logic           pend;     // byte awaiting commit
		i2cs_wr_type    pend_wr;  // byte awaiting commit
	} i2cs_state_type;

	i2cs_state_type st_q;         // registered state
	i2cs_state_type st_d;         // next state
	logic           scl_rise;     // scl rising edge
	logic           scl_fall;     // scl falling edge
	logic           sda_rise;     // sda rising edge
	logic           start_ev;     // start or repeated start
	logic           stop_ev;      // stop condition
	logic           byte_end;     // eighth-clock fall of rx byte
	logic           push;         // commit to write queue
	logic           q_ready;      // write queue has room

	// bus events from synced lines only
	assign scl_rise = st_q.scl_s & ~st_q.scl_p;
	assign scl_fall = ~st_q.scl_s & st_q.scl_p;
	assign sda_rise = st_q.sda_s & ~st_q.sda_p;
	assign start_ev = st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s;
	assign stop_ev  = st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s;
	assign byte_end = (st_q.state == ST_RX) & scl_fall
		& (st_q.cnt == `I2CS_BIT_CNT);

	// engine next state
	always_comb begin
		st_d       = st_q;
		st_d.scl_m = scl_in;
		st_d.scl_s = st_q.scl_m;
		st_d.scl_p = st_q.scl_s;
		st_d.sda_m = sda_in;
		st_d.sda_s = st_q.sda_m;
		st_d.sda_p = st_q.sda_s;
		st_d.sda_o = 1'b0;
		// data goes live on sda rise; a held-low bus commits at next byte
		push = st_q.pend & (sda_rise | byte_end);
		if (push) begin
			st_d.pend = 1'b0;
		end
		if (start_ev) begin
			// repeated start keeps the filter choice
			st_d.state = ST_RX;
			st_d.phase = PH_ADDR;
			st_d.cnt   = 4'h0;
			st_d.oe    = 1'b0;
		end else if (stop_ev) begin
			// pointer kept, slow filters back, go deaf
			st_d.state = ST_WAIT;
			st_d.hs    = 1'b0;
			st_d.ptr   = st_q.ptr;
			st_d.oe    = 1'b0;
		end else begin
			case (st_q.state)
				ST_WAIT: begin
					// scl ignored here until a start
					st_d.state = ST_WAIT;
				end
				ST_RX: begin
					if (scl_rise) begin
						st_d.sh  = {st_q.sh[6:0], st_q.sda_s};
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (byte_end) begin
						// default answer: ack, go on receiving
						st_d.state = ST_ACKS;
						st_d.oe    = 1'b1;
						st_d.after = ST_RX;
						st_d.cnt   = 4'h0;
						case (st_q.phase)
							PH_ADDR: begin
								if (st_q.sh == `I2CS_WR_ADDR_BYTE) begin
									st_d.phase = PH_PTR;
								end else if (st_q.sh == `I2CS_RD_ADDR_BYTE) begin
									st_d.after = ST_TX;
								end else if (st_q.sh[7:3] == `I2CS_HS_CODE) begin
									// master code: nack, fast filters
									st_d.hs    = 1'b1;
									st_d.oe    = 1'b0;
									st_d.after = ST_WAIT;
								end else begin
									// foreign address: stay off the bus
									st_d.state = ST_WAIT;
									st_d.oe    = 1'b0;
								end
							end
							PH_PTR: begin
								// any pointer value is acked
								st_d.ptr   = st_q.sh;
								st_d.phase = PH_DATA;
							end
							default: begin
								if (q_ready & ~st_q.pend) begin
									st_d.pend         = 1'b1;
									st_d.pend_wr.addr = st_q.ptr;
									st_d.pend_wr.data = st_q.sh;
									st_d.ptr = st_q.ptr + 8'h01;
								end else begin
									// queue full or byte still pending: nack, byte dropped
									st_d.oe = 1'b0;
								end
							end
						endcase
					end
				end
				ST_ACKS: begin
					// release on ninth fall, or drive first read bit; master level here unread
					if (scl_fall) begin
						st_d.state = st_q.after;
						st_d.oe    = 1'b0;
						if (st_q.after == ST_TX) begin
							st_d.sh = rd_data;
							st_d.oe = ~rd_data[7];
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						st_d.cnt = st_q.cnt + 4'h1;
					end else if (scl_fall) begin
						if (st_q.cnt == `I2CS_BIT_CNT) begin
							st_d.oe    = 1'b0;
							st_d.state = ST_MACK;
							st_d.ptr   = st_q.ptr + 8'h01;
						end else begin
							// next bit, msb first
							st_d.sh = {st_q.sh[6:0], 1'b0};
							st_d.oe = ~st_q.sh[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						st_d.more = ~st_q.sda_s;
					end else if (scl_fall) begin
						if (st_q.more) begin
							// master acked: next register
							st_d.state = ST_TX;
							st_d.cnt   = 4'h0;
							st_d.sh    = rd_data;
							st_d.oe    = ~rd_data[7];
						end else begin
							// nack ends the read
							st_d.state = ST_WAIT;
						end
					end
				end
				default: begin
					st_d.state = ST_WAIT;
				end
			endcase
		end
	end

	// engine register; idle lines sit high
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q       <= '0;
			st_q.state <= ST_WAIT;
			st_q.after <= ST_WAIT;
			st_q.phase <= PH_ADDR;
			st_q.scl_m <= 1'b1;
			st_q.scl_s <= 1'b1;
			st_q.scl_p <= 1'b1;
			st_q.sda_m <= 1'b1;
			st_q.sda_s <= 1'b1;
			st_q.sda_p <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// committed writes wait here for the register bank
	i2cs_fifo #(
		.WIDTH (`I2CS_FIFO_WIDTH),
		.DEPTH (`I2CS_FIFO_DEPTH)
	) i2cs_fifo_inst (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (push),
		.in_data   (st_q.pend_wr),
		.in_ready  (q_ready),
		.out_valid (wr_valid),
		.out_data  (wr_entry),
		.out_ready (wr_ready)
	);

	assign sda_out       = st_q.sda_o;
	assign sda_oe        = st_q.oe;
	assign hs_filter_sel = st_q.hs;
	assign reg_ptr       = st_q.ptr;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// stop seen on synced lines
	sequence stop_s;
		stop_ev;
	endsequence
	// an address byte just completed
	sequence addr_end_s;
		byte_end && st_q.phase == PH_ADDR;
	endsequence

	foreign_addr_a: assert property (
		addr_end_s ##0 st_q.sh[7:1] != `I2CS_DEV_ADDR |=> !st_q.oe)
		else $error("foreign address acked");
	own_addr_a: assert property (
		addr_end_s ##0 st_q.sh[7:1] == `I2CS_DEV_ADDR && !start_ev
		&& !stop_ev |=> st_q.oe && st_q.state == ST_ACKS)
		else $error("own address not acked");
	stop_filter_a: assert property (stop_s |=> !hs_filter_sel)
		else $error("filters not slow after stop");
	hs_code_a: assert property (
		addr_end_s ##0 st_q.sh[7:3] == `I2CS_HS_CODE && !start_ev
		&& !stop_ev |=> hs_filter_sel && !sda_oe)
		else $error("master code handling wrong");
	ptr_ack_a: assert property (
		byte_end && st_q.phase == PH_PTR && !start_ev && !stop_ev
		|=> sda_oe && reg_ptr == $past(st_q.sh))
		else $error("pointer not taken or acked");
	commit_edge_a: assert property (
		st_q.pend && sda_rise |-> push ##1 !st_q.pend)
		else $error("commit missed on sda rise");
	stop_ptr_a: assert property (stop_s |=> $stable(reg_ptr))
		else $error("pointer changed on stop");
	tx_load_a: assert property (
		$rose(st_q.state == ST_TX) |-> sda_oe == !$past(rd_data[7]))
		else $error("wrong first read bit");
	oe_on_low_a: assert property ($rose(sda_oe) |-> $past(scl_fall))
		else $error("sda driven outside scl low");
	idle_deaf_a: assert property (
		st_q.state == ST_WAIT && !start_ev |=> st_q.state == ST_WAIT)
		else $error("left idle without start");
	tx_step_a: assert property (
		st_q.state == ST_TX && scl_fall && st_q.cnt == `I2CS_BIT_CNT
		&& !start_ev && !stop_ev |=> reg_ptr == $past(reg_ptr) + 8'h01)
		else $error("pointer not stepped after read");
endmodule

`default_nettype wire

// file: verification/i2cs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master: open-drain data, 64 ns clock period
module i2cs_master_model (
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_drv
);
	// idle bus, both lines released high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// one bit: data set in low phase, sampled mid-high
	task automatic bit_cyc(input logic b, output logic r);
		sda_drv = b;
		#20 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
		#12;
	endtask
	// start or repeated start, clock left low
	task automatic start();
		sda_drv = 1'b1;
		#12 scl = 1'b1;
		#20 sda_drv = 1'b0;
		#20 scl = 1'b0;
		#12;
	endtask
	// stop, both lines left high until next start
	task automatic stop();
		sda_drv = 1'b0;
		#12 scl = 1'b1;
		#20 sda_drv = 1'b1;
		#40;
	endtask
	// byte out msb first, ninth bit released for the answer
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_cyc(d[i], r);
		bit_cyc(1'b1, r);
		ack = ~r;
	endtask
	// byte in, then master ack or nack
	task automatic recv(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
		bit_cyc(~ack, r);
	endtask
endmodule
`default_nettype wire

// file: verification/i2c_register_slave_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defines.svh"
module i2c_register_slave_port_tb
	import i2cs_pkg::*;
;
	logic        core_clk, reset, scl, sda_drv, sda;
	logic        sda_out, sda_oe, hs_filter_sel, wr_valid, wr_ready;
	logic [7:0]  reg_ptr, rd_data;
	i2cs_wr_type wr_entry;
	logic [7:0]  bank [256];    // register bank behind the port
	int          fail_count, num_checks;
	logic        a;             // last ack seen by the master
	logic [7:0]  d;             // last byte read back
	// open-drain data line with pull-up
	assign sda = sda_drv & ~sda_oe;
	assign rd_data = bank[reg_ptr];
	i2cs_port i2cs_port_inst (.core_clk(core_clk), .reset(reset),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.hs_filter_sel(hs_filter_sel), .reg_ptr(reg_ptr),
		.rd_data(rd_data), .wr_valid(wr_valid), .wr_entry(wr_entry),
		.wr_ready(wr_ready));
	i2cs_master_model i2cs_master_model_inst (.sda(sda), .scl(scl),
		.sda_drv(sda_drv));
	// bank takes queue head on handshake
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) bank[wr_entry.addr] <= wr_entry.data;
	end
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait until the write queue is empty
	task automatic wait_drain();
		int n;
		n = 0;
		@(negedge core_clk);
		while (wr_valid !== 1'b0) begin
			n++;
			if (n > 100) begin
				fail_count++;
				tally_and_finish();
			end
			@(negedge core_clk);
		end
	endtask
	// foreign address, then own address byte without a start
	task automatic s_foreign();
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(8'h3E, a);
		chk_bit(a, 1'b0);
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		chk_bit(a, 1'b0);
		i2cs_master_model_inst.stop();
	endtask
	// three-byte sequential write from pointer 0x10
	task automatic s_write();
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.send(8'h10, a);
		chk_bit(a, 1'b1);
		for (int i = 0; i < 3; i++) begin
			i2cs_master_model_inst.send(8'(8'hA5 ^ (i * 8'h5F)), a);
			chk_bit(a, 1'b1);
		end
		i2cs_master_model_inst.stop();
		wait_drain();
		for (int i = 0; i < 3; i++) begin
			chk_byte(bank[8'h10 + i], 8'(8'hA5 ^ (i * 8'h5F)));
		end
		chk_byte(reg_ptr, 8'h13);
		chk_bit(hs_filter_sel, 1'b0);
	endtask
	// set pointer, repeated start, read three bytes back
	task automatic s_read();
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.send(8'h10, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_RD_ADDR_BYTE, a);
		chk_bit(a, 1'b1);
		for (int i = 0; i < 3; i++) begin
			i2cs_master_model_inst.recv(i < 2, d);
			chk_byte(d, 8'(8'hA5 ^ (i * 8'h5F)));
		end
		i2cs_master_model_inst.stop();
		chk_byte(reg_ptr, 8'h13);
	endtask
	// master code, write at 0xFF with wrap, read at wrapped pointer
	task automatic s_hs();
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send({`I2CS_HS_CODE, 3'h5}, a);
		chk_bit(a, 1'b0);
		repeat (4) @(negedge core_clk);
		chk_bit(hs_filter_sel, 1'b1);
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.send(8'hFF, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.send(8'h96, a);
		i2cs_master_model_inst.start();
		chk_bit(hs_filter_sel, 1'b1);
		i2cs_master_model_inst.send(`I2CS_RD_ADDR_BYTE, a);
		i2cs_master_model_inst.recv(1'b0, d);
		chk_byte(d, 8'h00);
		i2cs_master_model_inst.stop();
		chk_bit(hs_filter_sel, 1'b0);
		chk_byte(bank[8'hFF], 8'h96);
		chk_byte(reg_ptr, 8'h01);
	endtask
	// bank stalls: four bytes fill the queue, fifth is refused
	task automatic s_full();
		@(posedge core_clk) wr_ready <= 1'b0;
		// keep bus edges off the sampling edge
		@(negedge core_clk);
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		i2cs_master_model_inst.send(8'h20, a);
		for (int i = 0; i < 5; i++) begin
			i2cs_master_model_inst.send(8'(8'h11 * (i + 1)), a);
			chk_bit(a, i < 4);
		end
		i2cs_master_model_inst.stop();
		chk_bit(wr_valid, 1'b1);
		@(posedge core_clk) wr_ready <= 1'b1;
		wait_drain();
		for (int i = 0; i < 4; i++) begin
			chk_byte(bank[8'h20 + i], 8'(8'h11 * (i + 1)));
		end
		chk_byte(bank[8'h24], 8'h00);
	endtask
	// master code, reset mid-run, outputs idle, then port works again
	task automatic s_reset();
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send({`I2CS_HS_CODE, 3'h2}, a);
		chk_bit(a, 1'b0);
		chk_bit(hs_filter_sel, 1'b1);
		@(posedge core_clk) reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		chk_bit(hs_filter_sel, 1'b0);
		chk_byte(reg_ptr, 8'h00);
		chk_bit(sda_oe, 1'b0);
		chk_bit(sda_out, 1'b0);
		chk_bit(wr_valid, 1'b0);
		repeat (8) @(negedge core_clk);
		i2cs_master_model_inst.start();
		i2cs_master_model_inst.send(`I2CS_WR_ADDR_BYTE, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.send(8'h30, a);
		chk_bit(a, 1'b1);
		i2cs_master_model_inst.stop();
		chk_byte(reg_ptr, 8'h30);
	endtask
	initial begin
		reset = 1'b1;
		wr_ready = 1'b1;
		fail_count = 0;
		num_checks = 0;
		foreach (bank[i]) bank[i] = 8'h00;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		repeat (8) @(posedge core_clk);
		// bus edges land between sampling edges from here on
		@(negedge core_clk);
		s_foreign();
		s_write();
		s_read();
		s_hs();
		s_full();
		s_reset();
		tally_and_finish();
	end
	// hang guard
	initial begin
		#300000;
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
